// ===== design/external_line_event_ctrl.sv
// Register file, pending logic and request outputs of the line event unit.
// What this block does
// [R1] A line's interrupt request passes only when its interrupt-open bit is 1.
// [R2] Event request of a line passes only when its event-open bit is 1.
// [R3] Rising edges trigger only when the line's rise select bit is 1.
// [R4] Falling edges trigger only when the line's fall select bit is 1.
// [R5] Writing 1 to a zero soft trigger bit sets the line's pending flag.
// [R6] Soft triggers produce requests only on opened lines.
// [R7] Clearing a pending flag by writing 1 also clears its soft trigger bit.
// [R8] Software writes zero to bits 31 to 20 of configuration registers.
// [R9] All mask, select and soft trigger registers reset to zero.
// [R10] A selected edge sets the line's pending flag.
// [R11] Pending flags clear only on a written 1; written 0 leaves them.
// [R12] Selected edge on an event-opened line gives one event pulse.
// [R13] Lines 0-17 come from pins, 18 supply monitor, 19 wakeup timer.
// [R14] Both selects set means every edge of the line triggers.
// [R15] Interrupt request stands while pending and interrupt-open are both 1.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module external_line_event_ctrl
  import line_event_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  input  wire logic [GPIO_LINES-1:0] gpio_lines,
  input  wire logic                  supply_monitor_out,
  input  wire logic                  wakeup_timer,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [NUM_LINES-1:0]       intr_req,
  output logic [NUM_LINES-1:0]       event_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_LINES-1:0] intr_open_ff, nxt_intr_open;
  logic [NUM_LINES-1:0] evt_open_ff, nxt_evt_open;
  logic [NUM_LINES-1:0] rise_sel_ff, nxt_rise_sel;
  logic [NUM_LINES-1:0] fall_sel_ff, nxt_fall_sel;
  logic [NUM_LINES-1:0] soft_trig_ff, nxt_soft_trig;
  logic [NUM_LINES-1:0] pending_ff, nxt_pending;
  logic [NUM_LINES-1:0] intr_req_ff, nxt_intr_req;
  logic [NUM_LINES-1:0] event_ff, nxt_event;
  logic                 aw_ff, nxt_aw;
  logic                 w_ff, nxt_w;
  logic                 bvalid_ff, nxt_bvalid;
  logic [1:0]           bresp_ff, nxt_bresp;
  logic [7:0]           awaddr_ff, nxt_awaddr;
  logic [31:0]          wdata_ff, nxt_wdata;
  logic [3:0]           wstrb_ff, nxt_wstrb;
  logic                 rvalid_ff, nxt_rvalid;
  logic [31:0]          rdata_ff, nxt_rdata;
  logic [1:0]           rresp_ff, nxt_rresp;
  logic                 awready_ff, nxt_awready;
  logic                 wready_ff, nxt_wready;
  logic                 arready_ff, nxt_arready;
  logic [NUM_LINES-1:0] line_in;
  logic [NUM_LINES-1:0] edge_trig;
  logic                 wr_go;
  logic [NUM_LINES-1:0] wmask;
  logic [NUM_LINES-1:0] wval;
  logic [NUM_LINES-1:0] soft_set;
  logic [NUM_LINES-1:0] pend_clr;

  // Known offsets for both the read and the write decoder.
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_INTR_OPEN) || (a == OFF_EVT_OPEN) ||
              (a == OFF_RISE_SEL) || (a == OFF_FALL_SEL) ||
              (a == OFF_SOFT_TRIG) || (a == OFF_PENDING);
  endfunction

  // Line sources: pins, then the supply monitor, then the wakeup timer.
  assign line_in = {wakeup_timer, supply_monitor_out, gpio_lines};  // R13

  line_edge_detect #(
    .WIDTH    (NUM_LINES)
  ) u_edge (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clk_en   (clk_en),
    .line_in  (line_in),
    .rise_sel (rise_sel_ff),
    .fall_sel (fall_sel_ff),
    .trig     (edge_trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are taken in either order.
  always_comb
  begin
    nxt_aw     = aw_ff;
    nxt_w      = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    wr_go      = 1'b0;
    if (s_axi_awvalid && !aw_ff && !bvalid_ff)
    begin
      nxt_aw     = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff && !bvalid_ff)
    begin
      nxt_w     = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (aw_ff && w_ff)
    begin
      wr_go      = 1'b1;
      nxt_aw     = 1'b0;
      nxt_w      = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = reg_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    // Ready follows the next holding state so that it can leave a flop.
    nxt_awready = !nxt_aw && !nxt_bvalid;
    nxt_wready  = !nxt_w && !nxt_bvalid;
  end

  // Write lanes below bit 20 only; upper bits are dropped.
  always_comb
  begin
    wmask = {{4{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wval  = wdata_ff[NUM_LINES-1:0] & wmask;  // R8
  end

  // Read channel: one cycle from the taken address to rvalid.
  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && !rvalid_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_INTR_OPEN: nxt_rdata = {12'h000, intr_open_ff};
        OFF_EVT_OPEN:  nxt_rdata = {12'h000, evt_open_ff};
        OFF_RISE_SEL:  nxt_rdata = {12'h000, rise_sel_ff};
        OFF_FALL_SEL:  nxt_rdata = {12'h000, fall_sel_ff};
        OFF_SOFT_TRIG: nxt_rdata = {12'h000, soft_trig_ff};
        OFF_PENDING:   nxt_rdata = {12'h000, pending_ff};
        default:       nxt_rdata = 32'h00000000;
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
    nxt_arready = !nxt_rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, soft trigger and pending flags.
  always_comb
  begin
    nxt_intr_open = intr_open_ff;
    nxt_evt_open  = evt_open_ff;
    nxt_rise_sel  = rise_sel_ff;
    nxt_fall_sel  = fall_sel_ff;
    nxt_soft_trig = soft_trig_ff;
    soft_set      = '0;
    pend_clr      = '0;
    if (wr_go)
    begin
      unique case (awaddr_ff)
        OFF_INTR_OPEN: nxt_intr_open = (intr_open_ff & ~wmask) | wval;
        OFF_EVT_OPEN:  nxt_evt_open  = (evt_open_ff & ~wmask) | wval;
        OFF_RISE_SEL:  nxt_rise_sel  = (rise_sel_ff & ~wmask) | wval;
        OFF_FALL_SEL:  nxt_fall_sel  = (fall_sel_ff & ~wmask) | wval;
        OFF_SOFT_TRIG:
        begin
          soft_set      = wval & ~soft_trig_ff;  // R5
          nxt_soft_trig = soft_trig_ff | wval;
        end
        OFF_PENDING:   pend_clr = wval;  // R11
        default:       soft_set = '0;
      endcase
    end
    // A pending clear also drops the soft trigger bit.
    nxt_soft_trig = nxt_soft_trig & ~pend_clr;  // R7
    // Set wins over a clear in the same cycle.
    nxt_pending = (pending_ff & ~pend_clr) | edge_trig | soft_set;  // R10 R5
    // Interrupt request follows pending and the interrupt-open bit.
    nxt_intr_req = nxt_pending & nxt_intr_open;  // R1 R6 R15
    // Event pulse lasts one cycle and does not touch pending.
    nxt_event = (edge_trig | soft_set) & evt_open_ff;  // R2 R6 R12
  end

  // Register stage for all state; frozen while clk_en is low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      intr_open_ff <= REG_RESET;  // R9
      evt_open_ff  <= REG_RESET;
      rise_sel_ff  <= REG_RESET;
      fall_sel_ff  <= REG_RESET;
      soft_trig_ff <= REG_RESET;
      pending_ff   <= REG_RESET;
      intr_req_ff  <= REG_RESET;
      event_ff     <= REG_RESET;
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      bvalid_ff    <= 1'b0;
      bresp_ff     <= RESP_OKAY;
      awaddr_ff    <= 8'h00;
      wdata_ff     <= 32'h00000000;
      wstrb_ff     <= 4'h0;
      rvalid_ff    <= 1'b0;
      rdata_ff     <= 32'h00000000;
      rresp_ff     <= RESP_OKAY;
      awready_ff   <= 1'b1;
      wready_ff    <= 1'b1;
      arready_ff   <= 1'b1;
    end
    else if (clk_en)
    begin
      intr_open_ff <= nxt_intr_open;
      evt_open_ff  <= nxt_evt_open;
      rise_sel_ff  <= nxt_rise_sel;
      fall_sel_ff  <= nxt_fall_sel;
      soft_trig_ff <= nxt_soft_trig;
      pending_ff   <= nxt_pending;
      intr_req_ff  <= nxt_intr_req;
      event_ff     <= nxt_event;
      aw_ff        <= nxt_aw;
      w_ff         <= nxt_w;
      bvalid_ff    <= nxt_bvalid;
      bresp_ff     <= nxt_bresp;
      awaddr_ff    <= nxt_awaddr;
      wdata_ff     <= nxt_wdata;
      wstrb_ff     <= nxt_wstrb;
      rvalid_ff    <= nxt_rvalid;
      rdata_ff     <= nxt_rdata;
      rresp_ff     <= nxt_rresp;
      awready_ff   <= nxt_awready;
      wready_ff    <= nxt_wready;
      arready_ff   <= nxt_arready;
    end
  end

  // Every bus and request output comes straight from its own flop.
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign intr_req      = intr_req_ff;
  assign event_pulse   = event_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the request paths.
  sequence rise_seen(int i);
    rise_sel_ff[i] && line_in[i] && !$past(line_in[i]);
  endsequence

  property masked_intr_p;
    @(posedge aclk) disable iff (!aresetn)
      (intr_req_ff != '0) |-> ((intr_req_ff & ~intr_open_ff) == '0 ||
                               $changed(intr_open_ff));
  endproperty
  intr_masked_a: assert property (masked_intr_p)  // R1
    else $error("interrupt request on a closed line");

  event_masked_a: assert property (  // R2
    @(posedge aclk) disable iff (!aresetn)
    clk_en |=> ((event_ff & ~$past(evt_open_ff)) == '0))
    else $error("event pulse on a closed line");

  rise_sets_a: assert property (  // R3 R10
    @(posedge aclk) disable iff (!aresetn)
    ((clk_en && $past(clk_en)) and rise_seen(3)) |=> pending_ff[3])
    else $error("selected rising edge did not set pending");

  no_edge_sel_a: assert property (  // R4
    @(posedge aclk) disable iff (!aresetn)
    (rise_sel_ff == '0 && fall_sel_ff == '0) |-> edge_trig == '0)
    else $error("trigger with no edge selected");

  soft_set_a: assert property (  // R5
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && soft_set[3]) |=> pending_ff[3] && soft_trig_ff[3])
    else $error("soft trigger did not set pending");

  clr_soft_a: assert property (  // R7
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && pend_clr[3] && !soft_set[3]) |=> !soft_trig_ff[3])
    else $error("soft trigger bit not cleared with pending");

  pend_hold_a: assert property (  // R11
    @(posedge aclk) disable iff (!aresetn)
    (pending_ff[3] && !pend_clr[3]) |=> pending_ff[3])
    else $error("pending flag dropped without a write of one");

  evt_pulse_a: assert property (  // R12
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && edge_trig[18] && evt_open_ff[18]) |=> event_ff[18])
    else $error("event pulse missing after selected edge");

  intr_follow_a: assert property (  // R15
    @(posedge aclk) disable iff (!aresetn)
    clk_en |=> intr_req_ff == (pending_ff & intr_open_ff))
    else $error("interrupt request does not follow pending and open");

  reset_zero_a: assert property (  // R9
    @(posedge aclk)
    !aresetn |=> (intr_open_ff == '0 && soft_trig_ff == '0))
    else $error("registers not zero after reset");
endmodule
`default_nettype wire

// ===== design/line_event_pkg.sv
// Package with register map, widths and reset values of the line event unit.
package line_event_pkg;
  localparam int          NUM_LINES     = 20;
  localparam int          GPIO_LINES    = 18;
  localparam int          SUPPLY_LINE   = 18;
  localparam int          WAKEUP_LINE   = 19;
  localparam logic [7:0]  OFF_INTR_OPEN = 8'h00;
  localparam logic [7:0]  OFF_EVT_OPEN  = 8'h04;
  localparam logic [7:0]  OFF_RISE_SEL  = 8'h08;
  localparam logic [7:0]  OFF_FALL_SEL  = 8'h0c;
  localparam logic [7:0]  OFF_SOFT_TRIG = 8'h10;
  localparam logic [7:0]  OFF_PENDING   = 8'h14;
  localparam logic [19:0] REG_RESET     = 20'h00000;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== design/line_edge_detect.sv
// Per-line edge detector with rising and falling selects.
`timescale 1ns/1ps
`default_nettype none
module line_edge_detect
  import line_event_pkg::*;
#(
  parameter int WIDTH = NUM_LINES
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] line_in,
  input  wire logic [WIDTH-1:0] rise_sel,
  input  wire logic [WIDTH-1:0] fall_sel,
  output logic      [WIDTH-1:0] trig
);
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] nxt_prev;

  // Next sample of each line; the previous sample gives edge history.
  always_comb
  begin
    nxt_prev = line_in;
  end

  // Sample register, held while the clock enable is low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_ff <= REG_RESET;
    else if (clk_en)
      prev_ff <= nxt_prev;
  end

  // Each line fires on a selected edge; both selects give every edge.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_line
      assign trig[i] = clk_en &&
        ((rise_sel[i] && line_in[i] && !prev_ff[i]) ||  // R3 R14
         (fall_sel[i] && !line_in[i] && prev_ff[i]));   // R4 R14
    end
  endgenerate
endmodule
`default_nettype wire

// ===== testbench/far_end_model.sv
// Model of the interrupt controller and event consumers at the far side.
`timescale 1ns/1ps
`default_nettype none
module far_end_model
  import line_event_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [NUM_LINES-1:0] intr_req,
  input  wire logic [NUM_LINES-1:0] event_pulse,
  output logic      [15:0]          event_count_ff,
  output logic      [NUM_LINES-1:0] intr_seen_ff
);
  logic [15:0]          nxt_event_count;
  logic [NUM_LINES-1:0] nxt_intr_seen;

  //////////////////////////////////////////////////////////////////////////
  // Each pulsing line in a cycle is one event taken; request levels are remembered.
  always_comb
  begin
    nxt_event_count = event_count_ff + 16'($countones(event_pulse));
    nxt_intr_seen   = intr_seen_ff | intr_req;
  end

  // Registers the consumer state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      event_count_ff <= 16'h0000;
      intr_seen_ff   <= '0;
    end
    else
    begin
      event_count_ff <= nxt_event_count;
      intr_seen_ff   <= nxt_intr_seen;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/external_line_event_ctrl_bench.sv
// Self-checking bench of the line event unit.
`timescale 1ns/1ps
`default_nettype none
module external_line_event_ctrl_bench;
  import line_event_pkg::*;
  typedef struct packed
  {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en = 1'b1;
  logic [17:0] gpio_lines = '0;
  logic        supply_monitor_out = 1'b0;
  logic        wakeup_timer = 1'b0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [19:0] intr_req, event_pulse, intr_seen;
  logic [15:0] ev_cnt, e0;
  int          errors = 0, n_checks = 0, i;
  row_t        rows [5] = '{
    '{8'h00, 32'h000a5a5a, 32'h000a5a5a, RESP_OKAY},
    '{8'h04, 32'h0005a5a5, 32'h0005a5a5, RESP_OKAY},
    '{8'h08, 32'h000fffff, 32'h000fffff, RESP_OKAY},
    '{8'h0c, 32'h00012345, 32'h00012345, RESP_OKAY},
    '{8'h18, 32'h00000001, 32'h00000000, RESP_SLVERR}};

  // Clock at 100 MHz.
  always #5 aclk = ~aclk;

  external_line_event_ctrl dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(clk_en), .gpio_lines(gpio_lines),
    .supply_monitor_out(supply_monitor_out), .wakeup_timer(wakeup_timer),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .intr_req(intr_req),
    .event_pulse(event_pulse));

  far_end_model far (.aclk(aclk), .aresetn(aresetn), .intr_req(intr_req),
    .event_pulse(event_pulse), .event_count_ff(ev_cnt),
    .intr_seen_ff(intr_seen));

  //////////////////////////////////////////////////////////////////////////
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  // Write cycle; readiness is judged before the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 50 && !tb; n++)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r  = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!tb) errors++;
  endtask

  // Read cycle, then compares the data with the expectation.
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
    logic ta, tr;
    tr = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 50 && !tr; n++)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!tr) errors++;
    chk(nm, e, d);
  endtask

  // Lets a line change settle into pending and request outputs.
  task automatic settle();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake.
  initial
  begin
    repeat (5000) @(posedge aclk);
    errors++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i++)
      rdc(8'(4 * i), 32'h0, "reset value");
    $display("Test reset done");
    for (i = 0; i < 5; i++)
    begin
      wr(rows[i].a, rows[i].d);
      chk("write resp", 32'(rows[i].r), 32'(r));
      rdc(rows[i].a, rows[i].e, "readback");
      chk("read resp", 32'(rows[i].r), 32'(r));
      wr(rows[i].a, 32'h0);
    end
    $display("Test register rows done");
    wr(OFF_INTR_OPEN, 32'h8);
    wr(OFF_RISE_SEL, 32'h8);
    gpio_lines[3] <= 1'b1;
    settle();
    chk("intr_req rise", 32'h8, 32'(intr_req));
    rdc(OFF_PENDING, 32'h8, "pending rise");
    wr(OFF_PENDING, 32'h0);
    rdc(OFF_PENDING, 32'h8, "pending kept");
    wr(OFF_PENDING, 32'h8);
    rdc(OFF_PENDING, 32'h0, "pending cleared");
    @(posedge aclk);
    gpio_lines[3] <= 1'b0;
    settle();
    rdc(OFF_PENDING, 32'h0, "fall unselected");
    $display("Test edges done");
    wr(OFF_SOFT_TRIG, 32'h48);
    rdc(OFF_PENDING, 32'h48, "soft pending");
    @(negedge aclk);
    chk("intr_req soft", 32'h8, 32'(intr_req));
    wr(OFF_PENDING, 32'h48);
    rdc(OFF_SOFT_TRIG, 32'h0, "soft cleared");
    @(negedge aclk);
    chk("intr_req idle", 32'h0, 32'(intr_req));
    $display("Test soft trigger done");
    wr(OFF_EVT_OPEN, 32'h40000);
    wr(OFF_RISE_SEL, 32'hc0000);
    wr(OFF_FALL_SEL, 32'h40000);
    @(negedge aclk);
    e0 = ev_cnt;
    @(posedge aclk);
    supply_monitor_out <= 1'b1;
    wakeup_timer       <= 1'b1;
    settle();
    @(posedge aclk);
    supply_monitor_out <= 1'b0;
    wakeup_timer       <= 1'b0;
    settle();
    chk("event count", 32'(e0 + 16'h2), 32'(ev_cnt));
    rdc(OFF_PENDING, 32'hc0000, "internal lines");
    @(negedge aclk);
    chk("intr masked", 32'h0, 32'(intr_req));
    chk("intr seen", 32'h8, 32'(intr_seen));
    $display("Test events done");
    // A pulse on a line while the clock enable is low must leave no trace.
    wr(OFF_PENDING, 32'hc0000);
    @(negedge aclk);
    e0 = ev_cnt;
    @(posedge aclk);
    clk_en             <= 1'b0;
    supply_monitor_out <= 1'b1;
    settle();
    @(posedge aclk);
    supply_monitor_out <= 1'b0;
    settle();
    @(posedge aclk);
    clk_en <= 1'b1;
    settle();
    chk("frozen events", 32'(e0), 32'(ev_cnt));
    rdc(OFF_PENDING, 32'h0, "frozen pending");
    $display("Test clock enable done");
    // A reset in mid-run must bring the configuration back to zero.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(OFF_RISE_SEL, 32'h0, "rise after reset");
    rdc(OFF_EVT_OPEN, 32'h0, "event after reset");
    rdc(OFF_INTR_OPEN, 32'h0, "intr after reset");
    $display("Test mid-run reset done");
    conclude();
  end
endmodule
`default_nettype wire
